// ---- verilog/jlc_pkg.sv ----
/*
 * Shared constants and types for the link control and test block.
 * Assumes a 20 MHz APB clock and 32-bit APB data.
 */
package jlc_pkg;

	localparam int          APB_ADDR_W     = 12;
	localparam int          APB_DATA_W     = 32;
	localparam int          CLK_PERIOD_NS  = 50;

	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_SW_SYNC    = 10'h203;
	localparam logic [9:0]  IDX_LINK_CTRL  = 10'h204;
	localparam logic [9:0]  IDX_TEST_SEL   = 10'h205;
	localparam logic [9:0]  IDX_DEVICE_ID  = 10'h206;
	localparam logic [9:0]  IDX_STATUS     = 10'h20A;

	localparam logic [7:0]  SW_SYNC_RST    = 8'h01;
	localparam logic [7:0]  LINK_CTRL_RST  = 8'h03;
	localparam logic [7:0]  TEST_SEL_RST   = 8'h00;
	localparam logic [7:0]  DEVICE_ID_RST  = 8'h00;

	localparam int          CTRL_UPPER_BIT = 4;
	localparam int          CTRL_SYNC_LSB  = 2;
	localparam int          CTRL_ENC_BIT   = 1;
	localparam int          CTRL_SCR_BIT   = 0;
	localparam int          CTRL_FIELD_W   = 5;
	localparam int          TEST_FIELD_W   = 5;

	localparam int          LANE_UPPER_BASE = 4;
	localparam logic [3:0]  LANE_UPPER_MAXL = 4'h4;
	localparam logic [1:0]  ILA_DID_MFRAME  = 2'h1;
	localparam logic [15:0] CLOCK_PATTERN   = 16'h00FF;

	typedef enum logic [1:0] {
		SYNC_SRC_SE   = 2'h0,
		SYNC_SRC_TS   = 2'h1,
		SYNC_SRC_SW   = 2'h2,
		SYNC_SRC_RSVD = 2'h3
	} jlc_sync_src_e;

	typedef enum logic [4:0] {
		TP_NORMAL    = 5'h00,
		TP_PRBS7     = 5'h01,
		TP_PRBS15    = 5'h02,
		TP_PRBS23    = 5'h03,
		TP_RAMP      = 5'h04,
		TP_TRANSPORT = 5'h05,
		TP_D215      = 5'h06,
		TP_K285      = 5'h07,
		TP_ILA       = 5'h08,
		TP_RPAT      = 5'h09,
		TP_HOLD_LOW  = 5'h0A,
		TP_HOLD_HIGH = 5'h0B,
		TP_PRBS9     = 5'h0D,
		TP_PRBS31    = 5'h0E,
		TP_CLOCK     = 5'h0F,
		TP_K287      = 5'h10
	} jlc_test_e;

	// Field order matches the control register bits 4:0
	typedef struct packed {
		logic          upper_lane_map;
		jlc_sync_src_e sync_source;
		logic          sample_encoding;
		logic          scrambler_enable;
	} jlc_cfg_s;

endpackage

// ---- verilog/jlc_sync_select.sv ----
/*
 * Sync request source selection with pin synchronisers.
 * Assumes both sync pins are asynchronous, active low, and that the
 * software bit and selector come from flops on pclk.
 */
`timescale 1ns/100ps
module jlc_sync_select (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  single_ended_sync_n_pin,
	input  wire logic                  timestamp_sync_n_pin,
	input  wire logic                  timestamp_receiver_enable,
	input  wire jlc_pkg::jlc_sync_src_e sync_source,
	input  wire logic                  software_sync_request,
	output logic                       sync_request,
	output logic                       pin_sync_n
);
	import jlc_pkg::*;

	logic [1:0] se_ff_r;
	logic [1:0] ts_ff_r;
	logic       pin_n;

	// Idle high so a fresh reset never shows a false request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se_ff_r <= 2'h3;
			ts_ff_r <= 2'h3;
		end else begin
			se_ff_r <= {se_ff_r[0], single_ended_sync_n_pin};
			ts_ff_r <= {ts_ff_r[0], timestamp_sync_n_pin};
		end
	end

	// Timestamp receiver off means the pin cannot be heard
	always_comb begin
		case (sync_source)
			SYNC_SRC_TS: pin_n = ts_ff_r[1] | ~timestamp_receiver_enable;
			SYNC_SRC_SW: pin_n = 1'b1;
			default:     pin_n = se_ff_r[1];
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_request <= 1'b0;
			pin_sync_n   <= 1'b1;
		end else begin
			sync_request <= ~pin_n | ~software_sync_request;
			pin_sync_n   <= pin_n;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	se_pin_path_a: assert property (
		(sync_source == SYNC_SRC_SE && software_sync_request) |=>
		sync_request == !$past(se_ff_r[1]))
		else $error("single ended sync not followed");
	ts_pin_path_a: assert property (
		(sync_source == SYNC_SRC_TS && software_sync_request
		 && timestamp_receiver_enable) |=> sync_request == !$past(ts_ff_r[1]))
		else $error("timestamp sync not followed");
	sw_only_a: assert property (
		(sync_source == SYNC_SRC_SW && software_sync_request) |=> !sync_request)
		else $error("pins leak into software sync");
	sw_request_a: assert property (
		!software_sync_request |=> sync_request)
		else $error("software request lost");
	rsvd_src_a: assert property (
		(sync_source == SYNC_SRC_RSVD && software_sync_request) |=>
		sync_request == !$past(se_ff_r[1]))
		else $error("reserved source not defaulted");

endmodule

// ---- verilog/jlc_link_control_test.sv ----
/*
 * Link control and test pattern registers for a serial transmit link,
 * with APB slave, lane mapping, sync source and test decode.
 * Assumes link enable, mode encoding and lane count come from other
 * register logic on pclk; sync pins are asynchronous.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps

module jlc_link_control_test #(
	parameter int NUM_LANES = 8
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [jlc_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [jlc_pkg::APB_DATA_W-1:0] pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic [jlc_pkg::APB_DATA_W-1:0]     prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          link_enable,
	input  wire logic                          link_uses_64b66b,
	input  wire logic [3:0]                    link_lane_count,
	input  wire logic                          timestamp_receiver_enable,
	input  wire logic                          single_ended_sync_n_pin,
	input  wire logic                          timestamp_sync_n_pin,
	input  wire logic                          ila_active,
	input  wire logic [1:0]                    ila_multiframe_index,
	output jlc_pkg::jlc_cfg_s                  link_cfg,
	output jlc_pkg::jlc_test_e                 test_pattern,
	output logic [15:0]                        test_word,
	output logic                               hold_low,
	output logic                               hold_high,
	output logic                               scrambler_active,
	output logic [NUM_LANES-1:0]               lane_enable,
	output logic                               sync_request,
	output logic                               ila_did_valid,
	output logic [7:0]                         ila_did_value,
	output logic                               link_block_reset_n,
	output logic                               serializer_power_down,
	output logic                               link_clock_gate_en
);
	import jlc_pkg::*;

	logic [CTRL_FIELD_W-1:0] ctrl_r;
	logic [TEST_FIELD_W-1:0] test_sel_r;
	logic [7:0]              device_id_r;
	logic                    sw_sync_r;
	logic                    setup;
	logic                    access_wr;
	logic [9:0]              idx;
	logic                    hit_ok;
	logic [7:0]              rd_byte;
	logic                    pin_sync_n;
	jlc_test_e               test_nxt;

	function automatic logic fn_mapped(input logic [9:0] i);
		return (i == IDX_SW_SYNC) || (i == IDX_LINK_CTRL) || (i == IDX_TEST_SEL)
			|| (i == IDX_DEVICE_ID) || (i == IDX_STATUS);
	endfunction

	function automatic jlc_test_e fn_test_decode(input logic [4:0] v);
		jlc_test_e t;
		t = TP_NORMAL;
		case (v)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
			5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h10: t = jlc_test_e'(v);
			default: t = TP_NORMAL;
		endcase
		return t;
	endfunction

	function automatic logic [NUM_LANES-1:0] fn_lane_mask(input logic upper,
			input logic [3:0] cnt);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (i < int'(cnt)) begin
				m[i] = 1'b1;
			end
		end
		if (upper) begin
			m = m << LANE_UPPER_BASE;
		end
		return m[NUM_LANES-1:0];
	endfunction

	// APB decode; misaligned and unmapped words are errors
	assign setup     = psel & ~penable;
	assign access_wr = psel & penable & pwrite & pstrb[0];
	assign idx       = paddr[11:2];
	assign pready    = 1'b1;

	always_comb begin
		hit_ok = (paddr[1:0] == 2'h0) && fn_mapped(idx);
	end

	always_comb begin
		if (idx == IDX_SW_SYNC) begin
			rd_byte = {7'h00, sw_sync_r};
		end else if (idx == IDX_LINK_CTRL) begin
			rd_byte = {3'h0, ctrl_r};
		end else if (idx == IDX_TEST_SEL) begin
			rd_byte = {3'h0, test_sel_r};
		end else if (idx == IDX_DEVICE_ID) begin
			rd_byte = device_id_r;
		end else if (idx == IDX_STATUS) begin
			rd_byte = {3'h0, pin_sync_n, test_pattern != TP_NORMAL,
				scrambler_active, sync_request, link_enable};
		end else begin
			rd_byte = 8'h00;
		end
	end

	// Answer captured at setup so prdata comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= hit_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr <= ~hit_ok;
		end
	end

	// Reserved bits are not stored, so they read back zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= LINK_CTRL_RST[CTRL_FIELD_W-1:0];
		end else if (access_wr && hit_ok && idx == IDX_LINK_CTRL) begin
			ctrl_r <= pwdata[CTRL_FIELD_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_sel_r <= TEST_SEL_RST[TEST_FIELD_W-1:0];
		end else if (access_wr && hit_ok && idx == IDX_TEST_SEL) begin
			test_sel_r <= pwdata[TEST_FIELD_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_id_r <= DEVICE_ID_RST;
		end else if (access_wr && hit_ok && idx == IDX_DEVICE_ID) begin
			device_id_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_sync_r <= SW_SYNC_RST[0];
		end else if (access_wr && hit_ok && idx == IDX_SW_SYNC) begin
			sw_sync_r <= pwdata[0];
		end
	end

	// Config fields go straight out; changes while enabled are software's risk
	assign link_cfg = jlc_cfg_s'(ctrl_r);

	jlc_sync_select u_sync (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.single_ended_sync_n_pin   (single_ended_sync_n_pin),
		.timestamp_sync_n_pin      (timestamp_sync_n_pin),
		.timestamp_receiver_enable (timestamp_receiver_enable),
		.sync_source               (link_cfg.sync_source),
		.software_sync_request     (sw_sync_r),
		.sync_request              (sync_request),
		.pin_sync_n                (pin_sync_n)
	);

	always_comb begin
		test_nxt = fn_test_decode(test_sel_r);
	end

	// Test pattern outputs, registered; 8B/10B-only codes are not policed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_pattern <= TP_NORMAL;
			test_word    <= 16'h0000;
			hold_low     <= 1'b0;
			hold_high    <= 1'b0;
		end else begin
			test_pattern <= test_nxt;
			test_word    <= (test_nxt == TP_CLOCK) ? CLOCK_PATTERN : 16'h0000;
			hold_low     <= (test_nxt == TP_HOLD_LOW);
			hold_high    <= (test_nxt == TP_HOLD_HIGH);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scrambler_active <= 1'b0;
		end else begin
			scrambler_active <= link_uses_64b66b | link_cfg.scrambler_enable;
		end
	end

	// Upper mapping with more than four lanes is undefined; mask just shifts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_enable <= '0;
		end else if (!link_enable) begin
			lane_enable <= '0;
		end else begin
			lane_enable <= fn_lane_mask(link_cfg.upper_lane_map, link_lane_count);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ila_did_valid <= 1'b0;
			ila_did_value <= 8'h00;
		end else begin
			ila_did_valid <= ila_active && (ila_multiframe_index == ILA_DID_MFRAME);
			ila_did_value <= device_id_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_block_reset_n    <= 1'b0;
			serializer_power_down <= 1'b1;
			link_clock_gate_en    <= 1'b0;
		end else begin
			link_block_reset_n    <= link_enable;
			serializer_power_down <= ~link_enable;
			link_clock_gate_en    <= link_enable;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lane_lower_a: assert property (
		(link_enable && !link_cfg.upper_lane_map && link_lane_count != 4'h0
		 && int'(link_lane_count) <= NUM_LANES) |=>
		lane_enable[0] && $countones(lane_enable) == int'($past(link_lane_count)))
		else $error("lower lane map wrong");
	lane_upper_a: assert property (
		(link_enable && link_cfg.upper_lane_map && link_lane_count <= LANE_UPPER_MAXL)
		|=> lane_enable[3:0] == 4'h0
		&& $countones(lane_enable) == int'($past(link_lane_count)))
		else $error("upper lane map wrong");
	enc_write_a: assert property (
		(access_wr && hit_ok && idx == IDX_LINK_CTRL) |=>
		link_cfg.sample_encoding == $past(pwdata[CTRL_ENC_BIT]))
		else $error("sample encoding not stored");
	scramble_8b10b_a: assert property (
		!link_uses_64b66b |=> scrambler_active == $past(link_cfg.scrambler_enable))
		else $error("scrambler bit ignored");
	scramble_64b66b_a: assert property (
		link_uses_64b66b |=> scrambler_active)
		else $error("64b66b unscrambled");
	prbs_decode_a: assert property (
		(test_sel_r == 5'h0D) |=> test_pattern == TP_PRBS9)
		else $error("PRBS9 decode wrong");
	seq_decode_a: assert property (
		(test_sel_r >= 5'h04 && test_sel_r <= 5'h09) |=>
		test_pattern == jlc_test_e'($past(test_sel_r)))
		else $error("pattern 4..9 decode wrong");
	static_hold_a: assert property (
		(test_sel_r == 5'h0A) |=> hold_low && !hold_high)
		else $error("hold low missing");
	clock_pat_a: assert property (
		(test_sel_r == 5'h0F) |=> test_word == 16'h00FF && test_pattern == TP_CLOCK)
		else $error("clock pattern wrong");
	k287_pat_a: assert property (
		(test_sel_r == 5'h10) |=> test_pattern == TP_K287)
		else $error("K28.7 decode wrong");
	did_write_a: assert property (
		(access_wr && hit_ok && idx == IDX_DEVICE_ID) ##1 !access_wr [*2] |->
		ila_did_value == $past(pwdata[7:0], 2))
		else $error("device identifier not carried");
	ila_did_a: assert property (
		(ila_active && ila_multiframe_index == 2'h1) |=>
		ila_did_valid && ila_did_value == $past(device_id_r))
		else $error("identifier slot missed");
	link_off_a: assert property (
		!link_enable [*2] |-> !link_block_reset_n && serializer_power_down
		&& !link_clock_gate_en && lane_enable == '0)
		else $error("disabled link not held");
	rsvd_test_a: assert property (
		(test_sel_r == 5'h0C || test_sel_r >= 5'h11) |=> test_pattern == TP_NORMAL)
		else $error("reserved selector not normal");
	apb_err_a: assert property (
		(setup && !fn_mapped(idx)) |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	normal_decode_a: assert property (
		(test_sel_r == 5'h00) |=> test_pattern == TP_NORMAL && test_word == 16'h0000
		&& !hold_low && !hold_high)
		else $error("normal data not selected");
	prbs7_decode_a: assert property (
		(test_sel_r == 5'h01) |=> test_pattern == TP_PRBS7)
		else $error("PRBS7 decode wrong");
	prbs15_decode_a: assert property (
		(test_sel_r == 5'h02) |=> test_pattern == TP_PRBS15)
		else $error("PRBS15 decode wrong");
	prbs23_decode_a: assert property (
		(test_sel_r == 5'h03) |=> test_pattern == TP_PRBS23)
		else $error("PRBS23 decode wrong");
	prbs31_decode_a: assert property (
		(test_sel_r == 5'h0E) |=> test_pattern == TP_PRBS31)
		else $error("PRBS31 decode wrong");
	hold_high_a: assert property (
		(test_sel_r == 5'h0B) |=> hold_high && !hold_low)
		else $error("hold high missing");
	strobe_gate_a: assert property (
		(psel && penable && pwrite && !pstrb[0] && idx == IDX_DEVICE_ID) |=> $stable(device_id_r))
		else $error("unstrobed write stored");
	misalign_err_a: assert property (
		(setup && paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0000_0000)
		else $error("misaligned access not refused");
	link_on_a: assert property (
		link_enable |=> link_block_reset_n && !serializer_power_down && link_clock_gate_en)
		else $error("enabled link still held");
	status_read_a: assert property (
		(setup && idx == IDX_STATUS && paddr[1:0] == 2'h0) |=>
		prdata[1:0] == {$past(sync_request), $past(link_enable)})
		else $error("status readback wrong");

endmodule

// ---- sim/jlc_rx_model.sv ----
/*
 * Far-end receiver model: drives the two active-low sync request pins.
 * Assumes the bench says when the receiver has lost alignment.
 */
`timescale 1ns/100ps
module jlc_rx_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic lost_se,
	input  wire logic lost_ts,
	output logic      se_sync_n,
	output logic      ts_sync_n
);
	// Pins idle high; a lost link pulls them low after an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se_sync_n <= 1'b1;
			ts_sync_n <= 1'b1;
		end else begin
			se_sync_n <= !lost_se;
			ts_sync_n <= !lost_ts;
		end
	end
endmodule

// ---- sim/test_jlc_link_control_test.sv ----
/*
 * Self-checking bench for the link control and test block.
 * Assumes a zero wait state APB slave and the receiver model on sync pins.
 */
`timescale 1ns/100ps
module test_jlc_link_control_test;
	import jlc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, link_lane_count;
	logic        link_enable, link_uses_64b66b, timestamp_receiver_enable;
	logic        single_ended_sync_n_pin, timestamp_sync_n_pin, ila_active;
	logic        lost_se, lost_ts, hold_low, hold_high, scrambler_active;
	logic        sync_request, ila_did_valid, link_block_reset_n;
	logic        serializer_power_down, link_clock_gate_en;
	logic [1:0]  ila_multiframe_index;
	logic [7:0]  lane_enable, ila_did_value;
	logic [15:0] test_word;
	jlc_cfg_s    link_cfg;
	jlc_test_e   test_pattern;
	int          fail_count, n_checks, seed, i, k, v, len, r, src, p;
	int          m[4] = '{1, 3, 0, 0};
	int          msk[4] = '{'h01, 'h1F, 'h1F, 'hFF};

	jlc_link_control_test jlc_link_control_test_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.link_enable, .link_uses_64b66b, .link_lane_count, .timestamp_receiver_enable,
		.single_ended_sync_n_pin, .timestamp_sync_n_pin, .ila_active,
		.ila_multiframe_index, .link_cfg, .test_pattern, .test_word, .hold_low,
		.hold_high, .scrambler_active, .lane_enable, .sync_request, .ila_did_valid,
		.ila_did_value, .link_block_reset_n, .serializer_power_down, .link_clock_gate_en);

	jlc_rx_model jlc_rx_model_inst (.pclk, .presetn, .lost_se, .lost_ts,
		.se_sync_n(single_ended_sync_n_pin), .ts_sync_n(timestamp_sync_n_pin));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			fail_count++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int j, input int d);
		apb(12'h80C + 12'(4 * j), 1'b1, 32'(d));
		if (pstrb[0] === 1'b1) m[j] = d & msk[j];
	endtask

	task automatic rdchk(input int j);
		apb(12'h80C + 12'(4 * j), 1'b0, 32'h00000000);
		chk("prdata", m[j], rd);
		chk("pslverr", 0, err);
	endtask

	initial begin
		#5000000;
		fail_count++;
		summarize();
	end

	initial begin
		seed = 30;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		{link_enable, link_uses_64b66b, timestamp_receiver_enable} = '0;
		{lost_se, lost_ts, ila_active, ila_multiframe_index} = '0;
		link_lane_count = 4'h1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++) rdchk(i);
		apb(12'hA00, 1'b0, 32'h00000000);
		chk("pslverr", 1, err);
		apb(12'h811, 1'b0, 32'h00000000);
		chk("pslverr", 1, err);
		pstrb <= 4'h0;
		wr(3, 'h5A);
		pstrb <= 4'hF;
		rdchk(3);
		// Fields change only while the link is off
		for (i = 0; i < 8; i++) begin
			v = $random(seed) & 'h1F;
			wr(1, v);
			len = 1 + ($unsigned($random(seed)) % (v[4] ? 4 : 8));
			link_uses_64b66b <= 1'($random(seed));
			link_lane_count <= 4'(len);
			link_enable <= 1'b1;
			repeat (3) @(posedge pclk);
			#1;
			chk("link_cfg", v, link_cfg);
			chk("scrambler_active", link_uses_64b66b | v[0], scrambler_active);
			chk("lane_enable", ((1 << len) - 1) << (v[4] ? 4 : 0), lane_enable);
			chk("link_block_reset_n", 1, link_block_reset_n);
			@(posedge pclk);
			link_enable <= 1'b0;
			repeat (2) @(posedge pclk);
			#1;
			chk("lane_enable", 0, lane_enable);
			chk("link_block_reset_n", 0, link_block_reset_n);
			chk("serializer_power_down", 1, serializer_power_down);
			chk("link_clock_gate_en", 0, link_clock_gate_en);
			rdchk(1);
		end
		// 8B/10B mode so every code may be chosen
		link_uses_64b66b <= 1'b0;
		for (i = 0; i < 32; i++) begin
			wr(2, i);
			repeat (2) @(posedge pclk);
			#1;
			chk("test_pattern", (i <= 16 && i != 12) ? i : 0, test_pattern);
			chk("hold_low", i == 10, hold_low);
			chk("hold_high", i == 11, hold_high);
			chk("test_word", i == 15 ? 16'h00FF : 16'h0000, test_word);
		end
		for (i = 0; i < 32; i++) begin
			@(posedge pclk);
			r = $random(seed);
			src = r & 3;
			timestamp_receiver_enable <= r[3];
			lost_se <= r[4];
			lost_ts <= r[5];
			wr(1, (src << 2) | 3);
			wr(0, r[2]);
			repeat (5) @(posedge pclk);
			#1;
			p = src == 2 ? 0 : (src == 1 ? (r[3] & r[5]) : r[4]);
			chk("sync_request", p | !r[2], sync_request);
			apb(12'h828, 1'b0, 32'h00000000);
			chk("status", ((1 - p) << 4) | 4 | ((p | !r[2]) << 1), rd);
		end
		for (i = 0; i < 4; i++) begin
			v = $random(seed) & 'hFF;
			wr(3, v);
			ila_active <= 1'b1;
			ila_multiframe_index <= 2'(i);
			repeat (2) @(posedge pclk);
			#1;
			chk("ila_did_valid", i == 1, ila_did_valid);
			if (i == 1) chk("ila_did_value", v, ila_did_value);
			rdchk(3);
			@(posedge pclk);
			ila_active <= 1'b0;
		end
		// Mid-run reset must bring every register back to its reset value
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		m = '{1, 3, 0, 0};
		for (i = 0; i < 4; i++) rdchk(i);
		wr(1, 3);
		rdchk(1);
		summarize();
	end
endmodule
